// [hw/eap_top.sv]
`timescale 1ns/1ps
`include "eap_defines.svh"
module eap_top (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // sensor sample, same clock
  input  wire logic                    smp_valid_i,
  input  wire eap_pkg::eap_smp_t       smp_i,
  // device condition
  input  wire logic                    self_test_i,
  input  wire logic                    fault_rec_i,
  input  wire logic                    fault_unrec_i,
  output eap_pkg::eap_dev_state_t      device_state_o,
  // explicit request and reply
  input  wire logic                    req_valid_i,
  input  wire eap_pkg::eap_req_t       req_i,
  output logic                         req_ready_o,
  output logic                         resp_valid_o,
  output eap_pkg::eap_resp_t           resp_o,
  // connection open and close
  input  wire logic                    fo_valid_i,
  input  wire logic [255:0]            fo_cfg_i,
  input  wire logic                    close_i,
  output logic                         fo_done_o,
  output logic [7:0]                   fo_status_o,
  output logic [15:0]                  fo_ext_o,
  output logic [3:0]                   conn_cnt_o
);
  import eap_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // instance is one of the six assemblies
  function automatic logic asm_known(input logic [7:0] inst);
    asm_known = (inst == `INST_POS) || (inst == `INST_POSFLG) || (inst == `INST_POSVEL) ||
                (inst == `INST_ALL) || (inst == `INST_CFG) || (inst == `INST_EMPTY);
  endfunction : asm_known

  // byte count of an assembly, shared by data and size reads
  function automatic logic [5:0] asm_len(input logic [7:0] inst);
    case (inst)
      `INST_POS:    asm_len = `LEN_POS;
      `INST_POSFLG: asm_len = `LEN_POSFLG;
      `INST_POSVEL: asm_len = `LEN_POSVEL;
      `INST_ALL:    asm_len = `LEN_ALL;
      `INST_CFG:    asm_len = `LEN_CFG;
      `INST_EMPTY:  asm_len = `LEN_EMPTY;
      default:      asm_len = `LEN_EMPTY;
    endcase
  endfunction : asm_len

  // ----------------------------------------
  // sample snapshot
  // ----------------------------------------
  logic [31:0]    pos_r;        // captured position
  logic [31:0]    vel_r;        // captured velocity
  logic           alarm_r;      // captured alarm flag
  logic           warn_r;       // captured warning flag
  logic [255:0]   cfg_r;        // active encoder parameters
  logic [3:0]     conn_cnt_r;   // open i/o connections
  eap_dev_state_t dev_state_r;  // reported state

  // all fields move on one strobe so an image never mixes two samples
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_r   <= 32'h0;
      vel_r   <= 32'h0;
      alarm_r <= 1'b0;
      warn_r  <= 1'b0;
    end else if (smp_valid_i) begin
      pos_r   <= smp_i.pos;
      vel_r   <= smp_i.vel;
      alarm_r <= smp_i.alarm;
      warn_r  <= smp_i.warn;
    end
  end

  property p_snap;
    @(posedge clk_i) disable iff (!rst_n_i)
    !smp_valid_i |=> $stable(pos_r) && $stable(vel_r) && $stable(alarm_r);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot moved without sample");

  // ----------------------------------------
  // device state
  // ----------------------------------------
  // faults outrank self test, self test outranks connections; with neither, any connection means operational
  eap_dev_state_t dev_state_nxt;
  assign dev_state_nxt = fault_unrec_i      ? EAP_DS_UNREC :
                         fault_rec_i        ? EAP_DS_REC :
                         self_test_i        ? EAP_DS_SELFTEST :
                         (conn_cnt_r != 4'h0) ? EAP_DS_OPER : EAP_DS_STANDBY;

  // registered so the reply byte and the port agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dev_state_r <= EAP_DS_SELFTEST;
    end else begin
      dev_state_r <= dev_state_nxt;
    end
  end
  assign device_state_o = dev_state_r;

  property p_state_unrec;
    @(posedge clk_i) disable iff (!rst_n_i)
    fault_unrec_i |=> device_state_o == EAP_DS_UNREC;
  endproperty
  a_state_unrec: assert property (p_state_unrec) else $error("unrecoverable fault not shown");

  property p_state_oper;
    @(posedge clk_i) disable iff (!rst_n_i)
    !fault_unrec_i && !fault_rec_i && !self_test_i && conn_cnt_r != 4'h0 |=> device_state_o == EAP_DS_OPER;
  endproperty
  a_state_oper: assert property (p_state_oper) else $error("operational state not shown");

  // ----------------------------------------
  // assembly images
  // ----------------------------------------
  logic [7:0]   flg;     // flag byte
  logic [255:0] img_sel; // image of addressed instance
  assign flg = {6'h00, warn_r, alarm_r};
  // least significant byte sits lowest and is shifted out first
  assign img_sel = (req_i.inst == `INST_POS)    ? {224'h0, pos_r} :
                   (req_i.inst == `INST_POSFLG) ? {216'h0, flg, pos_r} :
                   (req_i.inst == `INST_POSVEL) ? {192'h0, vel_r, pos_r} :
                   (req_i.inst == `INST_ALL)    ? {184'h0, flg, vel_r, pos_r} :
                   (req_i.inst == `INST_CFG)    ? cfg_r : 256'h0;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  logic       busy;    // reply in progress
  logic       acc;     // request taken this cycle
  logic       is_get;  // read service
  logic       is_set;  // write service
  logic       cls_asm; // assembly class
  logic [5:0] len;     // byte count of instance
  logic [5:0] cnt_r;   // beats still to send
  assign busy    = cnt_r != 6'h00;
  assign acc     = req_valid_i && req_ready_o;
  assign is_get  = req_i.service == `SVC_GET;
  assign is_set  = req_i.service == `SVC_SET;
  assign cls_asm = req_i.class_id == `CLS_ASM;
  assign len     = asm_len(req_i.inst);
  // one request at a time; a reply cannot be stalled
  assign req_ready_o = !busy;

  logic [7:0]   ld_st;  // result code to load
  logic [255:0] ld_buf; // reply bytes to load
  logic [5:0]   ld_cnt; // beats to load
  logic         ld_has; // beats carry data

  // picks the reply; every unknown path ends in an error beat
  always_comb begin
    ld_st  = `GRC_PATH;
    ld_buf = 256'h0;
    ld_cnt = 6'h01;
    ld_has = 1'b0;
    if (req_i.class_id == `CLS_ROUTER) begin
      ld_st = `GRC_SVC;
    end else if (cls_asm && req_i.inst == 8'h00) begin
      // class level: only revision
      if (!is_get) begin
        ld_st = `GRC_SVC;
      end else if (req_i.attribute == `ATTR_REV) begin
        ld_st  = `GRC_OK;
        ld_buf = {240'h0, `ASM_REV};
        ld_cnt = 6'h02;
        ld_has = 1'b1;
      end else begin
        ld_st = `GRC_ATTR;
      end
    end else if (cls_asm && !asm_known(req_i.inst)) begin
      ld_st = `GRC_OBJ;
    end else if (cls_asm && is_set) begin
      // nothing is consumed, so no attribute takes a write
      ld_st = ((req_i.attribute == `ATTR_DATA) || (req_i.attribute == `ATTR_SIZE)) ?
              `GRC_NOSET : `GRC_ATTR;
    end else if (cls_asm && !is_get) begin
      ld_st = `GRC_SVC;
    end else if (cls_asm && req_i.attribute == `ATTR_DATA) begin
      ld_st  = `GRC_OK;
      ld_buf = img_sel;
      ld_cnt = (len == 6'h00) ? 6'h01 : len;
      ld_has = len != 6'h00;
    end else if (cls_asm && req_i.attribute == `ATTR_SIZE) begin
      ld_st  = `GRC_OK;
      ld_buf = {250'h0, len};
      ld_cnt = 6'h02;
      ld_has = 1'b1;
    end else if (cls_asm) begin
      ld_st = `GRC_ATTR;
    end else if (req_i.class_id == `CLS_IDENT && req_i.inst == 8'h01 &&
                 req_i.attribute == `ATTR_STATE) begin
      ld_st  = is_get ? `GRC_OK : `GRC_NOSET;
      ld_buf = {248'h0, dev_state_r};
      ld_has = is_get;
    end else begin
      ld_st = `GRC_PATH;
    end
  end

  // ----------------------------------------
  // reply shifter
  // ----------------------------------------
  logic [255:0] buf_r; // bytes still to send
  logic [7:0]   st_r;  // result code of reply
  logic         has_r; // reply carries data

  // image is frozen at acceptance, so a new sample mid reply is harmless
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 6'h00;
      buf_r <= 256'h0;
      st_r  <= `GRC_OK;
      has_r <= 1'b0;
    end else if (acc) begin
      cnt_r <= ld_cnt;
      buf_r <= ld_buf;
      st_r  <= ld_st;
      has_r <= ld_has;
    end else if (busy) begin
      cnt_r <= cnt_r - 6'h01;
      buf_r <= {8'h00, buf_r[255:8]};
    end
  end

  assign resp_valid_o    = busy;
  assign resp_o.status   = st_r;
  assign resp_o.data     = buf_r[7:0];
  assign resp_o.has_data = has_r;
  assign resp_o.last     = cnt_r == 6'h01;

  property p_router;
    @(posedge clk_i) disable iff (!rst_n_i)
    acc && req_i.class_id == `CLS_ROUTER |=>
      resp_valid_o && resp_o.last && !resp_o.has_data && resp_o.status == `GRC_SVC;
  endproperty
  a_router: assert property (p_router) else $error("router request not refused");

  property p_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    acc && cls_asm && is_set |=> resp_valid_o && resp_o.last && resp_o.status != `GRC_OK;
  endproperty
  a_set: assert property (p_set) else $error("assembly write accepted");

  property p_size110;
    @(posedge clk_i) disable iff (!rst_n_i)
    acc && cls_asm && is_get && req_i.inst == `INST_ALL && req_i.attribute == `ATTR_SIZE |=>
      resp_o.data == 8'h09 && !resp_o.last ##1 resp_o.data == 8'h00 && resp_o.last;
  endproperty
  a_size110: assert property (p_size110) else $error("size of instance 110 wrong");

  property p_inst1;
    @(posedge clk_i) disable iff (!rst_n_i)
    acc && cls_asm && is_get && req_i.inst == `INST_POS && req_i.attribute == `ATTR_DATA |=>
      resp_o.data == $past(pos_r[7:0]) && !resp_o.last ##3 resp_o.last;
  endproperty
  a_inst1: assert property (p_inst1) else $error("instance 1 image wrong");

  property p_flags;
    @(posedge clk_i) disable iff (!rst_n_i)
    acc && cls_asm && is_get && req_i.inst == `INST_POSFLG && req_i.attribute == `ATTR_DATA |->
      ##5 resp_o.last && resp_o.data[7:2] == 6'h00 && resp_o.data[0] == $past(alarm_r, 5);
  endproperty
  a_flags: assert property (p_flags) else $error("flag byte wrong");

  property p_inst3;
    @(posedge clk_i) disable iff (!rst_n_i)
    acc && cls_asm && is_get && req_i.inst == `INST_POSVEL && req_i.attribute == `ATTR_DATA |=>
      (resp_valid_o && !resp_o.last) [*7] ##1 resp_o.last;
  endproperty
  a_inst3: assert property (p_inst3) else $error("instance 3 length wrong");

  property p_cfg;
    @(posedge clk_i) disable iff (!rst_n_i)
    acc && cls_asm && is_get && req_i.inst == `INST_CFG && req_i.attribute == `ATTR_DATA |=>
      (resp_valid_o && !resp_o.last) [*8] ##24 resp_o.last;
  endproperty
  a_cfg: assert property (p_cfg) else $error("instance 105 length wrong");

  property p_empty;
    @(posedge clk_i) disable iff (!rst_n_i)
    acc && cls_asm && is_get && req_i.inst == `INST_EMPTY && req_i.attribute == `ATTR_DATA |=>
      resp_o.last && !resp_o.has_data && resp_o.status == `GRC_OK;
  endproperty
  a_empty: assert property (p_empty) else $error("instance 107 not empty");

  // ----------------------------------------
  // connection open check
  // ----------------------------------------
  logic       fo_conflict; // later open with other parameters
  logic       fo_inc;      // open counted
  logic       fo_dec;      // close counted
  logic [3:0] conn_nxt;    // next connection count
  logic       fo_done_r;   // open answered
  logic [7:0] fo_st_r;     // open result code
  assign fo_conflict = fo_valid_i && (conn_cnt_r != 4'h0) && (fo_cfg_i != cfg_r);
  // count saturates; a sixteenth open is still answered but not counted
  assign fo_inc   = fo_valid_i && !fo_conflict && (conn_cnt_r != 4'hF);
  assign fo_dec   = close_i && (conn_cnt_r != 4'h0);
  assign conn_nxt = (fo_inc && !fo_dec) ? conn_cnt_r + 4'h1 :
                    (!fo_inc && fo_dec) ? conn_cnt_r - 4'h1 : conn_cnt_r;

  // first open sets the parameters, later ones must match them
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r      <= `CFG_RST;
      conn_cnt_r <= 4'h0;
      fo_done_r  <= 1'b0;
      fo_st_r    <= `GRC_OK;
    end else begin
      if (fo_valid_i && conn_cnt_r == 4'h0) begin
        cfg_r <= fo_cfg_i;
      end
      conn_cnt_r <= conn_nxt;
      fo_done_r  <= fo_valid_i;
      fo_st_r    <= fo_conflict ? `GRC_CONFLICT : `GRC_OK;
    end
  end

  assign fo_done_o   = fo_done_r;
  assign fo_status_o = fo_st_r;
  assign fo_ext_o    = `EXT_CONFLICT;
  assign conn_cnt_o  = conn_cnt_r;

  property p_reject;
    @(posedge clk_i) disable iff (!rst_n_i)
    fo_valid_i && conn_cnt_r != 4'h0 && fo_cfg_i != cfg_r && !close_i |=>
      fo_done_o && fo_status_o == `GRC_CONFLICT && fo_ext_o == 16'h0000 && $stable(conn_cnt_r);
  endproperty
  a_reject: assert property (p_reject) else $error("differing open not rejected");

endmodule : eap_top

// [shared/eap_defines.svh]
// How it works
// - device state codes 0..5, 255 unsupported
// - message router class 0x02 answers no service
// - assembly gathers several attributes on one connection
// - input assemblies produce, none are consumed
// - service 0x0E returns the addressed attribute
// - service 0x10 finds no settable attribute
// - attribute 3 data, attribute 4 byte count
// - instance 1: position, 4 bytes
// - instance 2: position plus flags, 5 bytes
// - instance 3: position plus velocity, 8 bytes
// - instance 110: position, velocity, flags, 9 bytes
// - instance 105: encoder parameters, 32 bytes
// - instance 107: empty, size zero
// - differing second open rejected 0x0C, ext 0
// - multi-byte values least significant byte first
// - flag bit 0 alarm, bit 1 warning
// - position from sensor position attribute
// - velocity from sensor velocity attribute
// - alarm bit from sensor alarm attribute
`ifndef EAP_DEFINES_SVH
`define EAP_DEFINES_SVH
// ----------------------------------------
// services, classes, attributes
// ----------------------------------------
`define SVC_GET      8'h0E
`define SVC_SET      8'h10
`define CLS_IDENT    8'h01
`define CLS_ROUTER   8'h02
`define CLS_ASM      8'h04
`define ATTR_REV     8'h01
`define ATTR_DATA    8'h03
`define ATTR_SIZE    8'h04
`define ATTR_STATE   8'h08
`define ASM_REV      16'h0002
// ----------------------------------------
// assembly instances and their sizes
// ----------------------------------------
`define INST_POS     8'h01
`define INST_POSFLG  8'h02
`define INST_POSVEL  8'h03
`define INST_ALL     8'h6E
`define INST_CFG     8'h69
`define INST_EMPTY   8'h6B
`define LEN_POS      6'h04
`define LEN_POSFLG   6'h05
`define LEN_POSVEL   6'h08
`define LEN_ALL      6'h09
`define LEN_CFG      6'h20
`define LEN_EMPTY    6'h00
// ----------------------------------------
// general result codes and reset values
// ----------------------------------------
`define GRC_OK       8'h00
`define GRC_PATH     8'h05
`define GRC_SVC      8'h08
`define GRC_NOSET    8'h0E
`define GRC_ATTR     8'h14
`define GRC_OBJ      8'h16
`define GRC_CONFLICT 8'h0C
`define EXT_CONFLICT 16'h0000
`define CFG_RST      256'h0
`endif

// [shared/eap_pkg.sv]
`include "eap_defines.svh"
package eap_pkg;
  // ----------------------------------------
  // device state codes
  // ----------------------------------------
  typedef enum logic [7:0] {
    EAP_DS_NONE     = 8'h00,
    EAP_DS_SELFTEST = 8'h01,
    EAP_DS_STANDBY  = 8'h02,
    EAP_DS_OPER     = 8'h03,
    EAP_DS_REC      = 8'h04,
    EAP_DS_UNREC    = 8'h05,
    EAP_DS_NOSUP    = 8'hFF
  } eap_dev_state_t;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] pos;   // unsigned position value
    logic [31:0] vel;   // velocity value
    logic        alarm; // alarm flag
    logic        warn;  // warning flag
  } eap_smp_t;
  typedef struct packed {
    logic [7:0] service;
    logic [7:0] class_id;
    logic [7:0] inst;
    logic [7:0] attribute;
  } eap_req_t;
  typedef struct packed {
    logic [7:0] status;   // general result code
    logic [7:0] data;     // reply byte
    logic       has_data; // data byte is meaningful
    logic       last;     // final beat of reply
  } eap_resp_t;
endpackage : eap_pkg

// [testbench/eap_scanner_model.sv]
`timescale 1ns/1ps
module eap_scanner_model (
  // clock
  input  wire logic         clk_i,
  // explicit request handshake
  input  wire logic         req_ready_i,
  output logic              req_valid_o,
  output eap_pkg::eap_req_t req_o
);
  import eap_pkg::*;
  logic busy; // a request is owned by send
  initial begin
    req_valid_o = 1'b0;
    req_o       = '0;
    busy        = 1'b0;
  end
  // idle request lines toggle so a stale value never looks valid
  always @(posedge clk_i) begin
    #1;
    if (!busy) begin
      req_o = ~req_o;
    end
  end
  // hold the request until the edge that finds ready high
  task automatic send(input eap_req_t r);
    busy = 1'b1;
    @(posedge clk_i);
    #1;
    req_valid_o = 1'b1;
    req_o       = r;
    while (!req_ready_i) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    #1;
    req_valid_o = 1'b0;
    req_o       = ~r;
    @(posedge clk_i);
    busy = 1'b0;
  endtask : send
endmodule : eap_scanner_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import eap_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_i = 1'b0, rst_n_i = 1'b0, smp_valid_i = 1'b0, self_test_i = 1'b0;
  logic fault_rec_i = 1'b0, fault_unrec_i = 1'b0, fo_valid_i = 1'b0, close_i = 1'b0;
  logic req_valid_i, req_ready_o, resp_valid_o, fo_done_o;
  eap_smp_t smp_i = '0;
  eap_req_t req_i;
  eap_resp_t resp_o, e;
  eap_dev_state_t device_state_o;
  logic [255:0] fo_cfg_i = '0, cfg_a;
  logic [7:0] fo_status_o, flg;
  logic [15:0] fo_ext_o;
  logic [3:0] conn_cnt_o;
  int miscompares = 0, tests_run = 0, seed = 82580;
  eap_resp_t exp_q[$]; // expected reply beats, oldest first
  always #5 clk_i = ~clk_i;
  eap_top i_eap_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .smp_valid_i(smp_valid_i), .smp_i(smp_i),
    .self_test_i(self_test_i), .fault_rec_i(fault_rec_i), .fault_unrec_i(fault_unrec_i),
    .device_state_o(device_state_o), .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .resp_valid_o(resp_valid_o), .resp_o(resp_o), .fo_valid_i(fo_valid_i), .fo_cfg_i(fo_cfg_i),
    .close_i(close_i), .fo_done_o(fo_done_o), .fo_status_o(fo_status_o), .fo_ext_o(fo_ext_o),
    .conn_cnt_o(conn_cnt_o));
  eap_scanner_model i_eap_scanner_model (.clk_i(clk_i), .req_ready_i(req_ready_o),
    .req_valid_o(req_valid_i), .req_o(req_i));
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // data beats, least significant byte first
  task automatic exp_bytes(input logic [255:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({8'h00, v[8*i +: 8], 1'b1, i == n - 1});
    end
  endtask : exp_bytes
  // one beat carrying only a result code
  task automatic exp_code(input logic [7:0] st);
    exp_q.push_back({st, 8'h00, 1'b0, 1'b1});
  endtask : exp_code
  task automatic drain;
    for (int i = 0; i < 80 && (exp_q.size() != 0 || resp_valid_o); i++) @(posedge clk_i);
    #1;
    check(exp_q.size(), 0);
  endtask : drain
  task automatic get(input logic [7:0] s, c, n, a);
    i_eap_scanner_model.send({s, c, n, a});
  endtask : get
  // fresh random sample, one-cycle pulse
  task automatic sample;
    @(posedge clk_i);
    #1;
    smp_i = {$random(seed), $random(seed), 2'($random(seed))};
    smp_valid_i = 1'b1;
    flg = {6'h00, smp_i.warn, smp_i.alarm};
    @(posedge clk_i);
    #1;
    smp_valid_i = 1'b0;
  endtask : sample
  // open a connection and check the one-cycle answer
  task automatic open(input logic [255:0] cfg, input logic [7:0] st, input logic [3:0] cnt);
    @(posedge clk_i);
    #1;
    fo_valid_i = 1'b1;
    fo_cfg_i = cfg;
    @(posedge clk_i);
    #1;
    fo_valid_i = 1'b0;
    check(fo_done_o, 1);
    check(fo_status_o, st);
    check({fo_ext_o, conn_cnt_o}, {16'h0000, cnt});
    @(posedge clk_i);
    #1;
    check(fo_done_o, 0);
  endtask : open
  task automatic state_is(input logic [7:0] s);
    repeat (2) @(posedge clk_i);
    #1;
    check(device_state_o, s);
    exp_bytes(s, 1);
    get(8'h0E, 8'h01, 8'h01, 8'h08);
    drain;
  endtask : state_is
  // ----------------------------------------
  // reply watcher: oldest note against each beat
  // ----------------------------------------
  // mid-cycle look, so a beat is read while it stands and never at its own edge
  always @(negedge clk_i) begin
    if (rst_n_i && resp_valid_o) begin
      check(req_ready_o, 0);
      if (exp_q.size() == 0) check(1, 0);
      else begin
        e = exp_q.pop_front();
        check({resp_o.status, resp_o.has_data ? resp_o.data : 8'h00, resp_o.has_data, resp_o.last},
              {e.status, e.data, e.has_data, e.last});
      end
    end
  end
  // watchdog sized well above the planned traffic
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] inst [4] = '{8'h01, 8'h02, 8'h03, 8'h6E};
    logic [7:0] len [4] = '{8'h04, 8'h05, 8'h08, 8'h09};
    logic [31:0] err [8] = '{32'h1004_0103, 32'h1004_0104, 32'h0E02_0101, 32'h0E04_0703,
                             32'h4C04_0103, 32'h0E04_0105, 32'h0E09_0101, 32'h1001_0108};
    logic [7:0] code [8] = '{8'h0E, 8'h0E, 8'h08, 8'h16, 8'h08, 8'h14, 8'h05, 8'h0E};
    repeat (12) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    state_is(8'h02);
    $display("reset test done");
    // the four sampled images (instances 1, 2, 3, 110), with a new sample landing mid-reply
    sample();
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: exp_bytes(smp_i.pos, 4);
        1: exp_bytes({flg, smp_i.pos}, 5);
        2: exp_bytes({smp_i.vel, smp_i.pos}, 8);
        default: exp_bytes({flg, smp_i.vel, smp_i.pos}, 9);
      endcase
      get(8'h0E, 8'h04, inst[k], 8'h03);
      sample();
      drain;
      exp_bytes({8'h00, len[k]}, 2);
      get(8'h0E, 8'h04, inst[k], 8'h04);
      drain;
    end
    $display("input image test done");
    // refused services and unknown places, then revision and empty-instance reads
    for (int k = 0; k < 8; k++) begin
      exp_code(code[k]);
      get(err[k][31:24], err[k][23:16], err[k][15:8], err[k][7:0]);
      drain;
    end
    exp_bytes(16'h0002, 2);
    get(8'h0E, 8'h04, 8'h00, 8'h01);
    exp_code(8'h00);
    get(8'h0E, 8'h04, 8'h6B, 8'h03);
    exp_bytes(16'h0000, 2);
    get(8'h0E, 8'h04, 8'h6B, 8'h04);
    drain;
    $display("service test done");
    // connection opens and the configuration image
    for (int i = 0; i < 8; i++) cfg_a[32*i +: 32] = $random(seed);
    open(cfg_a, 8'h00, 4'h1);
    state_is(8'h03);
    exp_bytes(cfg_a, 32);
    get(8'h0E, 8'h04, 8'h69, 8'h03);
    drain;
    open(cfg_a ^ (256'h1 << 255), 8'h0C, 4'h1);
    open(cfg_a, 8'h00, 4'h2);
    close_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    close_i = 1'b0;
    state_is(8'h02);
    $display("open test done");
    // faults and self test, highest priority wins
    self_test_i = 1'b1;
    state_is(8'h01);
    fault_rec_i = 1'b1;
    state_is(8'h04);
    fault_unrec_i = 1'b1;
    state_is(8'h05);
    $display("state test done");
    report_and_stop();
  end
endmodule : tb_top
